// *** core/msdio_pattern_mem.sv ***
// eight-word store of digit patterns with a registered read port
// assumes writer and reader share clk_sys_in; read data lag the address by one cycle
`timescale 1ns/10ps
`default_nettype none
module msdio_pattern_mem
  import msdio_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic wr_en_in,
  input wire logic [DIGIT_IDX_WIDTH-1:0] wr_addr_in,
  input wire logic [PATTERN_WIDTH-1:0] wr_data_in,
  input wire logic [DIGIT_IDX_WIDTH-1:0] rd_addr_in,
  output logic [PATTERN_WIDTH-1:0] rd_data_out
);
  logic [PATTERN_WIDTH-1:0] mem_reg [DIGIT_COUNT];

  // cleared at reset so a blank display never shows stale patterns
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < DIGIT_COUNT; i++) begin
        mem_reg[i] <= PATTERN_RESET;
      end
    end else if (clk_en_in && wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  // registered read port
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= PATTERN_RESET;
    end else if (clk_en_in) begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end
endmodule : msdio_pattern_mem
`default_nettype wire

// *** core/msdio_pkg.sv ***
// shared constants for the multiplexed segment display and board i/o block
// assumes a single 10 MHz system clock; all widths fixed at board values
package msdio_pkg;
  // clock and scan timing
  localparam int CLK_FREQ_MHZ = 10;
  localparam int DIGIT_TIME_US = 1000; // each digit lit 1 ms, full scan 8 ms
  localparam int DIGIT_CYCLES = DIGIT_TIME_US * CLK_FREQ_MHZ;
  localparam int SCAN_CNT_WIDTH = 16;

  // display geometry
  localparam int DIGIT_COUNT = 8;
  localparam int DIGIT_IDX_WIDTH = 3;
  localparam int SEGMENT_COUNT = 7;
  localparam int PATTERN_WIDTH = 8; // segments a..g in bits 0..6, point in bit 7
  localparam int PATTERN_DP_BIT = 7;
  localparam logic [DIGIT_IDX_WIDTH-1:0] DIGIT_IDX_LAST = 3'h7;
  localparam logic [DIGIT_IDX_WIDTH-1:0] DIGIT_IDX_RESET = 3'h0;

  // board i/o widths
  localparam int BUTTON_COUNT = 5;
  localparam int SWITCH_COUNT = 16;
  localparam int LED_COUNT = 16;
  localparam int SYNC_WIDTH = BUTTON_COUNT + 1 + SWITCH_COUNT;

  // tri-colour pwm
  localparam int RGB_CHANNELS = 6; // two leds, red/green/blue each
  localparam int PWM_WIDTH = 8;
  localparam logic [PWM_WIDTH-1:0] PWM_DUTY_MAX = 8'h80; // 128 of 256 is 50%

  // reset values of the outputs (active-low lines idle high)
  localparam logic [DIGIT_COUNT-1:0] DIGIT_ENABLE_OFF = 8'hff;
  localparam logic [SEGMENT_COUNT-1:0] SEGMENT_OFF = 7'h7f;
  localparam logic [PATTERN_WIDTH-1:0] PATTERN_RESET = 8'h00;
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 22'h00_0020; // restart button idles high
endpackage : msdio_pkg

// *** core/msdio_top.sv ***
// board i/o front end: input synchronisers, led drive, 8-digit scanning display, tri-colour pwm
// assumes board pins arrive asynchronously and the pattern/duty inputs come from logic on clk_sys_in
//
// Notes on behaviour
// - five direction buttons read low at rest, high only while held.
// - restart button reads high at rest, low pressed; treated as active low.
// - slide switches give steady levels set by position only, never pulses.
// - every digit has seven independent segments, any of 128 patterns.
// - cathodes shared by all digits; segment lights only on the enabled digit.
// - tri-colour led shows the mix of its lit elements.
`timescale 1ns/10ps
`default_nettype none
module msdio_top
  import msdio_pkg::*;
#(
  parameter int DIGIT_CYCLES_P = DIGIT_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // board pins, asynchronous
  input wire logic [BUTTON_COUNT-1:0] button_in,
  input wire logic cpu_restart_n_in,
  input wire logic [SWITCH_COUNT-1:0] switch_in,
  // user-side controls, same clock
  input wire logic [LED_COUNT-1:0] led_value_in,
  input wire logic digit_wr_in,
  input wire logic [DIGIT_IDX_WIDTH-1:0] digit_addr_in,
  input wire logic [PATTERN_WIDTH-1:0] digit_pattern_in,
  input wire logic [RGB_CHANNELS*PWM_WIDTH-1:0] rgb_duty_in,
  // synchronised board levels
  output logic [BUTTON_COUNT-1:0] button_out,
  output logic cpu_restart_n_out,
  output logic [SWITCH_COUNT-1:0] switch_out,
  // board drive
  output logic [LED_COUNT-1:0] led_out,
  output logic [DIGIT_COUNT-1:0] digit_enable_n_out,
  output logic [SEGMENT_COUNT-1:0] segment_cathode_n_out,
  output logic decimal_point_n_out,
  output logic [RGB_CHANNELS-1:0] rgb_out
);
  // limits a requested duty to half the pwm period
  function automatic logic [PWM_WIDTH-1:0] clamp_duty(input logic [PWM_WIDTH-1:0] duty);
    clamp_duty = (duty > PWM_DUTY_MAX) ? PWM_DUTY_MAX : duty;
  endfunction : clamp_duty

  // one-hot active-low enable for a digit index
  function automatic logic [DIGIT_COUNT-1:0] enable_for(input logic [DIGIT_IDX_WIDTH-1:0] idx);
    enable_for = ~(8'h01 << idx);
  endfunction : enable_for

  localparam logic [SCAN_CNT_WIDTH-1:0] SCAN_CNT_LAST = SCAN_CNT_WIDTH'(DIGIT_CYCLES_P - 1);

  logic [SYNC_WIDTH-1:0] sync_meta_reg;
  logic [SYNC_WIDTH-1:0] sync_stable_reg;
  logic [SCAN_CNT_WIDTH-1:0] scan_cnt_reg;
  logic scan_tick;
  logic [DIGIT_IDX_WIDTH-1:0] digit_idx_reg;
  logic [DIGIT_IDX_WIDTH-1:0] shown_idx_reg;
  logic load_pending_reg;
  logic tick_seen_reg;
  logic [PATTERN_WIDTH-1:0] pattern_rd;
  logic [PWM_WIDTH-1:0] pwm_cnt_reg;

  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sync_meta_reg <= SYNC_RESET;
      sync_stable_reg <= SYNC_RESET;
    end else if (clk_en_in) begin
      sync_meta_reg <= {switch_in, cpu_restart_n_in, button_in};
      sync_stable_reg <= sync_meta_reg;
    end
  end

  // board levels passed on with polarity kept: buttons active high, restart active low
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      button_out <= SYNC_RESET[BUTTON_COUNT-1:0];
      cpu_restart_n_out <= SYNC_RESET[BUTTON_COUNT];
      switch_out <= SYNC_RESET[SYNC_WIDTH-1:BUTTON_COUNT+1];
    end else if (clk_en_in) begin
      button_out <= sync_stable_reg[BUTTON_COUNT-1:0];
      cpu_restart_n_out <= sync_stable_reg[BUTTON_COUNT];
      switch_out <= sync_stable_reg[SYNC_WIDTH-1:BUTTON_COUNT+1];
    end
  end

  // user leds: high lights, low darkens
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      led_out <= '0;
    end else if (clk_en_in) begin
      led_out <= led_value_in;
    end
  end

  // dwell counter; 1 ms per digit gives an 8 ms scan, 125 Hz, well above flicker
  assign scan_tick = (scan_cnt_reg == SCAN_CNT_LAST);
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      scan_cnt_reg <= '0;
    end else if (clk_en_in) begin
      if (scan_tick) begin
        scan_cnt_reg <= '0;
      end else begin
        scan_cnt_reg <= scan_cnt_reg + 16'h0001;
      end
    end
  end

  // digit index steps 0..7 and wraps, equal dwell for each
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      digit_idx_reg <= DIGIT_IDX_RESET;
    end else if (clk_en_in && scan_tick) begin
      if (digit_idx_reg == DIGIT_IDX_LAST) begin
        digit_idx_reg <= DIGIT_IDX_RESET;
      end else begin
        digit_idx_reg <= digit_idx_reg + 3'h1;
      end
    end
  end

  // full 8-bit pattern per digit, so all 128 segment combinations plus point are storable
  msdio_pattern_mem u_pattern_mem (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .wr_en_in(digit_wr_in),
    .wr_addr_in(digit_addr_in),
    .wr_data_in(digit_pattern_in),
    .rd_addr_in(digit_idx_reg),
    .rd_data_out(pattern_rd)
  );

  // the read register holds the new digit's pattern one edge after the tick, so the reload waits two
  // waiting only one edge would show the previous digit's pattern under the new enable for a cycle
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      tick_seen_reg <= 1'b0;
      load_pending_reg <= 1'b1;
      shown_idx_reg <= DIGIT_IDX_RESET;
    end else if (clk_en_in) begin
      tick_seen_reg <= scan_tick;
      load_pending_reg <= tick_seen_reg;
      if (load_pending_reg) begin
        shown_idx_reg <= digit_idx_reg;
      end
    end
  end

  // enable and pattern change on the same edge, so no ghost of the last digit appears
  // pattern refreshes on every edge but the one after the tick, so a write to the shown digit reaches the cathodes two edges after it is stored
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      digit_enable_n_out <= DIGIT_ENABLE_OFF;
      segment_cathode_n_out <= SEGMENT_OFF;
      decimal_point_n_out <= 1'b1;
    end else if (clk_en_in) begin
      if (load_pending_reg) begin
        digit_enable_n_out <= enable_for(digit_idx_reg);
      end
      if (load_pending_reg || (shown_idx_reg == digit_idx_reg)) begin
        segment_cathode_n_out <= ~pattern_rd[SEGMENT_COUNT-1:0];
        decimal_point_n_out <= ~pattern_rd[PATTERN_DP_BIT];
      end
    end
  end

  // free-running pwm base, 256 cycles, about 39 kHz
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pwm_cnt_reg <= '0;
    end else if (clk_en_in) begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end
  end

  // each colour element compared on its own, so lit elements mix
  // duty above half is clipped rather than wrapped to avoid a glaring steady on
  for (genvar ch = 0; ch < RGB_CHANNELS; ch++) begin : g_rgb
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
        rgb_out[ch] <= 1'b0;
      end else if (clk_en_in) begin
        rgb_out[ch] <= (pwm_cnt_reg < clamp_duty(rgb_duty_in[ch*PWM_WIDTH +: PWM_WIDTH]));
      end
    end
  end
endmodule : msdio_top
`default_nettype wire

// *** tb/msdio_assertions.sv ***
// checker for the scanning display and board i/o front end
// assumes binding to msdio_top with the same digit dwell parameter
`timescale 1ns/10ps
`default_nettype none
module msdio_chk
  import msdio_pkg::*;
#(
  parameter int DC = 12
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic digit_wr_in,
  input wire logic [RGB_CHANNELS*PWM_WIDTH-1:0] rgb_duty_in,
  input wire logic [LED_COUNT-1:0] led_value_in,
  input wire logic [LED_COUNT-1:0] led_out,
  input wire logic [DIGIT_COUNT-1:0] digit_enable_n_out,
  input wire logic [SEGMENT_COUNT-1:0] segment_cathode_n_out,
  input wire logic [RGB_CHANNELS-1:0] rgb_out
);
  logic [DIGIT_COUNT-1:0] en_q_reg;
  logic [15:0] dwell_reg;
  logic [1:0] chg_reg;
  logic [8:0] hi_reg [RGB_CHANNELS];
  logic chg;
  logic over;
  assign chg = digit_enable_n_out != en_q_reg;
  // dwell per digit; the first two changes are skipped since reset preload stretches digit 0
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      en_q_reg <= DIGIT_ENABLE_OFF;
      dwell_reg <= 16'h0000;
      chg_reg <= 2'h0;
    end else begin
      en_q_reg <= digit_enable_n_out;
      dwell_reg <= chg ? 16'h0001 : dwell_reg + 16'h0001;
      if (chg && chg_reg != 2'h3) chg_reg <= chg_reg + 2'h1;
    end
  end
  // length of the current unbroken high run of each colour channel, cleared when it goes low
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < RGB_CHANNELS; i++) hi_reg[i] <= 9'h000;
    end else begin
      for (int i = 0; i < RGB_CHANNELS; i++) hi_reg[i] <= rgb_out[i] ? hi_reg[i] + 9'h001 : 9'h000;
    end
  end
  always_comb begin
    over = 1'b0;
    for (int i = 0; i < RGB_CHANNELS; i++) over = over | (hi_reg[i] > 9'h080);
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  a_led_follow: assert property ($past(reset_in) || led_out == $past(led_value_in))
    else $error("led output not following request");
  a_enable_onehot: assert property ($past(reset_in) || $onehot(~digit_enable_n_out))
    else $error("digit enables not one-hot low");
  a_enable_dwell: assert property (chg && chg_reg >= 2'h2 |-> dwell_reg == 16'(DC))
    else $error("digit dwell wrong");
  a_enable_order: assert property (chg && en_q_reg != DIGIT_ENABLE_OFF |->
    digit_enable_n_out == {en_q_reg[6:0], en_q_reg[7]})
    else $error("digit order wrong");
  a_first_digit: assert property ($fell(reset_in) |=> digit_enable_n_out == 8'hfe)
    else $error("scan not restarting at digit zero");
  a_seg_with_en: assert property ($changed(segment_cathode_n_out) && !$past(digit_wr_in, 3) |-> chg)
    else $error("cathodes changed without enable");
  a_pwm_cap: assert property (!over)
    else $error("colour high for over half a period");
  a_pwm_off: assert property ($past(rgb_duty_in[7:0]) == 8'h00 && $past(rgb_duty_in[7:0], 2) == 8'h00
    |-> !rgb_out[0])
    else $error("colour lit at zero duty");
  c_wrap: cover property (chg && digit_enable_n_out == 8'hfe);
  c_pwm: cover property ($rose(rgb_out[2]));
  c_write: cover property (digit_wr_in ##3 $changed(segment_cathode_n_out));
endmodule : msdio_chk
bind msdio_top msdio_chk #(.DC(DIGIT_CYCLES_P)) u_chk (.*);
`default_nettype wire

// *** tb/msdio_board_model.sv ***
// board buttons and switches as seen at the block's pins
// assumes the bench sets the mechanical state; pins carry plain levels
`timescale 1ns/10ps
`default_nettype none
module msdio_board_model
  import msdio_pkg::*;
(
  input wire logic [BUTTON_COUNT-1:0] held_in,
  input wire logic restart_held_in,
  input wire logic [SWITCH_COUNT-1:0] position_in,
  output logic [BUTTON_COUNT-1:0] button_out,
  output logic cpu_restart_n_out,
  output logic [SWITCH_COUNT-1:0] switch_out
);
  // pulled down at rest, high while held
  assign button_out = held_in;
  // pulled up at rest, low while pressed
  assign cpu_restart_n_out = !restart_held_in;
  // steady level from position only
  assign switch_out = position_in;
endmodule : msdio_board_model
`default_nettype wire

// *** tb/tb.sv ***
// bench for the scanning display and board i/o front end
// assumes a 10 MHz clock and a 12-cycle digit dwell to keep the run short
`timescale 1ns/10ps
`default_nettype none
module tb;
  import msdio_pkg::*;
  localparam int DC = 12;
  logic clk_sys_in, reset_in, clk_en_in, digit_wr_in, cpu_restart_n_in, cpu_restart_n_out, restart_held;
  logic [BUTTON_COUNT-1:0] held, button_in, button_out;
  logic [SWITCH_COUNT-1:0] position, switch_in, switch_out;
  logic [LED_COUNT-1:0] led_value_in, led_out;
  logic [DIGIT_IDX_WIDTH-1:0] digit_addr_in;
  logic [PATTERN_WIDTH-1:0] digit_pattern_in;
  logic [RGB_CHANNELS*PWM_WIDTH-1:0] rgb_duty_in;
  logic [DIGIT_COUNT-1:0] digit_enable_n_out;
  logic [SEGMENT_COUNT-1:0] segment_cathode_n_out;
  logic decimal_point_n_out;
  logic [RGB_CHANNELS-1:0] rgb_out;
  logic [PATTERN_WIDTH-1:0] pt [DIGIT_COUNT] = '{8'h06, 8'h07, 8'h7f, 8'h80, 8'h00, 8'hff, 8'h55, 8'h2a};
  int n_fail = 0;
  int samples_checked = 0;
  msdio_top #(.DIGIT_CYCLES_P(DC)) u_dut (.*);
  msdio_board_model u_board (.held_in(held), .restart_held_in(restart_held), .position_in(position),
    .button_out(button_in), .cpu_restart_n_out(cpu_restart_n_in), .switch_out(switch_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // reset values, then the scan restarts on digit zero
  task automatic t_reset(input int n);
    @(posedge clk_sys_in) reset_in <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    #1;
    chk(digit_enable_n_out, DIGIT_ENABLE_OFF);
    chk({segment_cathode_n_out, decimal_point_n_out}, 8'hff);
    chk({rgb_out, led_out}, 0);
    @(posedge clk_sys_in) reset_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk(digit_enable_n_out, 8'hfe);
    $display("reset test done");
  endtask : t_reset
  // pin levels reach the outputs on the third edge, not before
  task automatic t_levels;
    @(posedge clk_sys_in);
    held <= 5'h15;
    restart_held <= 1'b1;
    position <= 16'ha5c3;
    led_value_in <= 16'h8001;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk(button_out, 0);
    chk(led_out, 16'h8001);
    @(posedge clk_sys_in);
    #1;
    chk({button_out, cpu_restart_n_out, switch_out}, {5'h15, 1'b0, 16'ha5c3});
    @(posedge clk_sys_in);
    held <= 5'h00;
    restart_held <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk({button_out, cpu_restart_n_out}, 6'h01);
    $display("levels test done");
  endtask : t_levels
  // back-to-back pattern writes, then two full scans compared digit by digit
  task automatic t_digits;
    int n;
    logic [DIGIT_COUNT-1:0] e;
    for (int i = 0; i < DIGIT_COUNT; i++) begin
      @(posedge clk_sys_in);
      digit_wr_in <= 1'b1;
      digit_addr_in <= i[2:0];
      digit_pattern_in <= pt[i];
    end
    @(posedge clk_sys_in) digit_wr_in <= 1'b0;
    #1;
    for (int k = 1; k <= 2 * DIGIT_COUNT; k++) begin
      e = ~(8'h01 << (k % DIGIT_COUNT));
      n = 0;
      while (digit_enable_n_out !== e && n < 9 * DC) begin
        @(posedge clk_sys_in);
        #1;
        n++;
      end
      chk(digit_enable_n_out, e);
      chk(segment_cathode_n_out, 7'(~pt[k % DIGIT_COUNT][6:0]));
      chk(decimal_point_n_out, 1'(~pt[k % DIGIT_COUNT][7]));
    end
    $display("digits test done");
  endtask : t_digits
  // high time over two pwm periods, duties above half clipped
  task automatic t_pwm;
    int cnt [RGB_CHANNELS] = '{default: 0};
    logic [PWM_WIDTH-1:0] d [RGB_CHANNELS] = '{8'h00, 8'h01, 8'h40, 8'h80, 8'hc8, 8'hff};
    @(posedge clk_sys_in) rgb_duty_in <= {d[5], d[4], d[3], d[2], d[1], d[0]};
    repeat (4) @(posedge clk_sys_in);
    repeat (512) begin
      @(posedge clk_sys_in);
      #1;
      for (int c = 0; c < RGB_CHANNELS; c++) cnt[c] += rgb_out[c];
    end
    for (int c = 0; c < RGB_CHANNELS; c++) chk(cnt[c], 2 * (d[c] > 8'h80 ? 8'h80 : d[c]));
    $display("pwm test done");
  endtask : t_pwm
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    {reset_in, clk_en_in, digit_wr_in, restart_held} = 4'hc;
    {held, position, led_value_in, digit_addr_in, digit_pattern_in, rgb_duty_in} = '0;
    t_reset(10);
    t_levels;
    t_digits;
    t_pwm;
    t_reset(2);
    wrap_up;
  end
  // about 730 cycles expected
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    n_fail++;
    wrap_up;
  end
endmodule : tb
`default_nettype wire
